// file: pll_cfg_pkg.sv
// Purpose: shared constants for the pll configuration and lock control block
// Assumes: 32-bit axi4-lite register bus, one clock
// Notes: register offsets are byte addresses
package pll_cfg_pkg;
	localparam int addr_w = 4;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [addr_w-1:0] pll_word_offset = 4'h0;
	localparam logic [addr_w-1:0] lock_ctrl_offset = 4'h4;
	localparam logic [addr_w-1:0] unlock_offset = 4'h8;
	// ****************************************
	// configuration word fields
	// ****************************************
	localparam int out_div_lsb = 16;
	localparam int usb_en_n_bit = 15;
	localparam int usb_div_lsb = 8;
	localparam int mult_lsb = 4;
	localparam int in_div_lsb = 0;
	localparam logic [31:0] pll_word_reserved_mask = 32'hfff8_7888;
	// ****************************************
	// control register fields and reset values
	// ****************************************
	localparam int pin_lock_bit = 13;
	localparam int mod_lock_bit = 12;
	localparam int dbg_en_bit = 3;
	localparam int tdo_use_bit = 0;
	localparam logic [31:0] ctrl_ones_mask = 32'h0000_0006;
	localparam logic dbg_en_reset = 1'b1;
	localparam logic tdo_use_reset = 1'b1;
	localparam logic lock_reset = 1'b0;
	// unlock key pair written to the unlock register in sequence; values are arbitrary
	localparam logic [31:0] unlock_key1 = 32'h0f1e_2d3c;
	localparam logic [31:0] unlock_key2 = 32'hc3d2_e1f0;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// file: pll_field_decode.sv
// Purpose: decode the configuration word pll fields into numeric factors
// Assumes: codes arrive from flip-flops
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module pll_field_decode
(
	input wire logic [2:0] out_code, // output divisor code
	input wire logic [2:0] usb_code, // usb input divider code
	input wire logic [2:0] mult_code, // multiplier code
	output logic [8:0] out_divisor, // output divide ratio
	output logic [3:0] usb_divisor, // usb input divide ratio
	output logic [4:0] multiplier // multiplication factor
);
	always_comb
	begin
		case (out_code)
			3'h0: out_divisor = 9'h001;
			3'h1: out_divisor = 9'h002;
			3'h2: out_divisor = 9'h004;
			3'h3: out_divisor = 9'h008;
			3'h4: out_divisor = 9'h010;
			3'h5: out_divisor = 9'h020;
			3'h6: out_divisor = 9'h040;
			default: out_divisor = 9'h100;
		endcase
		case (usb_code)
			3'h6: usb_divisor = 4'ha;
			3'h7: usb_divisor = 4'hc;
			default: usb_divisor = {1'b0, usb_code} + 4'h1;
		endcase
		case (mult_code)
			3'h7: multiplier = 5'h18;
			default: multiplier = {2'h0, mult_code} + 5'h0f;
		endcase
	end
endmodule
`default_nettype wire

// file: lock_gate.sv
// Purpose: gate write strobes to the pin-select and module-disable registers
// Assumes: strobes are one-cycle pulses from the system clock domain
// Notes: combinational; refused writes simply vanish
`timescale 1ns/1ps
`default_nettype none
module lock_gate
(
	input wire logic pin_lock, // pin select lock level
	input wire logic mod_lock, // module disable lock level
	input wire logic pin_wr_req, // requested pin select write
	input wire logic mod_wr_req, // requested module disable write
	output logic pin_wr_ok, // permitted pin select write
	output logic mod_wr_ok // permitted module disable write
);
	// pin select writes refused while locked
	assign pin_wr_ok = pin_wr_req & ~pin_lock;
	// module disable writes refused while locked
	assign mod_wr_ok = mod_wr_req & ~mod_lock;
endmodule
`default_nettype wire

// file: pll_config_and_lock_control.sv
// Purpose: configuration word holder and run-time lock control register bank
// Assumes: nonvolatile word and debug strap are stable across reset release
// Notes: axi4-lite slave, answers one cycle after both address and data are held
//
// What this block does
// - output divisor codes 000..111 give divide by 1,2,4,8,16,32,64,256.
// - the usb pll enable bit is active low, one disables and bypasses the usb pll.
// - multiplier codes 000..111 give factors 15,16,17,18,19,20,21,24.
// - usb pll fields exist only on variants with the usb function.
// - pin select register writes are refused while the pin select lock is set.
// - module disable register writes are refused while the module disable lock is set.
// - control bit 3 enables the debug port and resets to one.
// - control bit 0 selects tdo use in 2-wire debug and resets to one.
// - control bits 31-14 and 11-4 read zero, bits 2-1 read one.
// - lock bits change only after the unlock sequence.
// - the debug enable bit takes its reset value from the nonvolatile debug strap.
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pll_config_and_lock_control
#(
	parameter bit has_usb = 1'b1 // variant carries the usb function
)
(
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [31:0] nv_pll_word, // nonvolatile configuration word
	input wire logic nv_dbg_en, // nonvolatile debug enable strap
	input wire logic [pll_cfg_pkg::addr_w-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [pll_cfg_pkg::addr_w-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic pin_wr_req, // pin select register write request
	input wire logic mod_wr_req, // module disable register write request
	output logic pin_wr_ok, // pin select write permitted
	output logic mod_wr_ok, // module disable write permitted
	output logic [2:0] pll_in_divider, // pll input divider code
	output logic [8:0] pll_out_divisor, // pll output divide ratio
	output logic [4:0] pll_multiplier, // pll multiplication factor
	output logic usb_pll_enable_n, // usb pll disable and bypass, active low enable
	output logic [3:0] usb_pll_in_divider, // usb pll input divide ratio
	output logic debug_port_enable, // debug port enable
	output logic two_wire_tdo_use, // tdo used in 2-wire mode
	output logic pin_select_lock, // pin select lock level
	output logic module_disable_lock // module disable lock level
);
	import pll_cfg_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef enum logic [1:0] {unl_idle, unl_key1, unl_open} unlock_e;
	unlock_e unlock_reg;
	logic [31:0] pll_word_reg;
	logic init_reg;
	logic pin_lock_reg;
	logic mod_lock_reg;
	logic dbg_en_reg;
	logic tdo_use_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic [addr_w-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;
	logic wr_fire;
	logic [31:0] ctrl_view;
	logic [31:0] word_view;
	logic [31:0] ctrl_wr;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (st[i])
			begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ****************************************
	// configuration word capture
	// ****************************************
	// latched while reset is held and at the first edge after release, never written by software
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			init_reg <= 1'b1;
		end
		else
		begin
			init_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (init_reg)
		begin
			pll_word_reg <= nv_pll_word;
		end
	end

	// usb fields forced to disabled pattern on variants without usb
	always_comb
	begin
		word_view = pll_word_reg;
		if (!has_usb)
		begin
			word_view[usb_en_n_bit] = 1'b1;
			word_view[usb_div_lsb +: 3] = 3'h0;
		end
	end

	// reserved bits read back as stored; keeping them at one is up to the programmer
	assign pll_in_divider = word_view[in_div_lsb +: 3];
	// active low usb pll enable passes straight through
	assign usb_pll_enable_n = word_view[usb_en_n_bit];

	pll_field_decode u_decode
	(
		.out_code(word_view[out_div_lsb +: 3]),
		.usb_code(word_view[usb_div_lsb +: 3]),
		.mult_code(word_view[mult_lsb +: 3]),
		.out_divisor(pll_out_divisor),
		.usb_divisor(usb_pll_in_divider),
		.multiplier(pll_multiplier)
	);

	// ****************************************
	// write channel
	// ****************************************
	// hold one address and one data beat, fire when both are in and no response is pending
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready = !w_held_reg && !bvalid_reg;
	assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			else if (wr_fire)
			begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			else if (wr_fire)
			begin
				w_held_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= resp_okay;
		end
		else if (wr_fire)
		begin
			bvalid_reg <= 1'b1;
			case (awaddr_reg)
				pll_word_offset, lock_ctrl_offset, unlock_offset: bresp_reg <= resp_okay;
				default: bresp_reg <= resp_slverr;
			endcase
		end
		else if (s_axi_bready)
		begin
			bvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// ****************************************
	// unlock sequence
	// ****************************************
	// two full-word keys back to back open the locks; any other unlock write closes them
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			unlock_reg <= unl_idle;
		end
		else if (wr_fire && awaddr_reg == unlock_offset)
		begin
			case (unlock_reg)
				unl_idle: unlock_reg <= (wdata_reg == unlock_key1 && wstrb_reg == 4'hf) ? unl_key1 : unl_idle;
				unl_key1: unlock_reg <= (wdata_reg == unlock_key2 && wstrb_reg == 4'hf) ? unl_open : unl_idle;
				unl_open: unlock_reg <= unl_idle;
				default: unlock_reg <= unl_idle;
			endcase
		end
	end

	// ****************************************
	// control register
	// ****************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_lock_reg <= lock_reset;
			mod_lock_reg <= lock_reset;
		end
		// lock bits change only while unlocked
		else if (wr_fire && awaddr_reg == lock_ctrl_offset && unlock_reg == unl_open)
		begin
			pin_lock_reg <= ctrl_wr[pin_lock_bit];
			mod_lock_reg <= ctrl_wr[mod_lock_bit];
		end
	end

	// debug enable reloads from the strap at release
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dbg_en_reg <= dbg_en_reset;
			tdo_use_reg <= tdo_use_reset;
		end
		else if (init_reg)
		begin
			dbg_en_reg <= nv_dbg_en;
		end
		// debug and tdo bits writable from the low byte
		else if (wr_fire && awaddr_reg == lock_ctrl_offset)
		begin
			dbg_en_reg <= ctrl_wr[dbg_en_bit];
			tdo_use_reg <= ctrl_wr[tdo_use_bit];
		end
	end

	// fixed read values of unimplemented bits
	always_comb
	begin
		ctrl_view = ctrl_ones_mask;
		ctrl_view[pin_lock_bit] = pin_lock_reg;
		ctrl_view[mod_lock_bit] = mod_lock_reg;
		ctrl_view[dbg_en_bit] = dbg_en_reg;
		ctrl_view[tdo_use_bit] = tdo_use_reg;
	end

	// bytes without a strobe keep their current value, so a partial write leaves other fields alone
	assign ctrl_wr = merge(ctrl_view, wdata_reg, wstrb_reg);

	assign debug_port_enable = dbg_en_reg;
	assign two_wire_tdo_use = tdo_use_reg;
	assign pin_select_lock = pin_lock_reg;
	assign module_disable_lock = mod_lock_reg;

	lock_gate u_gate
	(
		.pin_lock(pin_lock_reg),
		.mod_lock(mod_lock_reg),
		.pin_wr_req(pin_wr_req),
		.mod_wr_req(mod_wr_req),
		.pin_wr_ok(pin_wr_ok),
		.mod_wr_ok(mod_wr_ok)
	);

	// ****************************************
	// read channel
	// ****************************************
	assign s_axi_arready = !rvalid_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rresp_reg <= resp_okay;
			rdata_reg <= '0;
		end
		else if (s_axi_arvalid && !rvalid_reg)
		begin
			rvalid_reg <= 1'b1;
			rresp_reg <= resp_okay;
			case (s_axi_araddr)
				pll_word_offset: rdata_reg <= word_view;
				lock_ctrl_offset: rdata_reg <= ctrl_view;
				unlock_offset: rdata_reg <= {30'h0, (unlock_reg == unl_open), (unlock_reg == unl_key1)};
				default:
				begin
					rdata_reg <= '0;
					rresp_reg <= resp_slverr;
				end
			endcase
		end
		else if (s_axi_rready)
		begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

endmodule
`default_nettype wire

// file: pll_config_and_lock_control_sva.sv
// Purpose: port-level checks for the pll configuration and lock control block
// Assumes: single clock, synchronous active-low reset
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module pll_config_and_lock_control_sva
#(
	parameter bit has_usb = 1'b1 // variant carries the usb function
)
(
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, active low
	input wire logic [31:0] nv_pll_word, // stored word
	input wire logic nv_dbg_en, // debug strap
	input wire logic s_axi_bvalid, // write response valid
	input wire logic pin_wr_req, // pin write request
	input wire logic mod_wr_req, // module write request
	input wire logic pin_wr_ok, // pin write permitted
	input wire logic mod_wr_ok, // module write permitted
	input wire logic [8:0] pll_out_divisor, // output ratio
	input wire logic [4:0] pll_multiplier, // multiplier
	input wire logic usb_pll_enable_n, // usb pll off
	input wire logic [3:0] usb_pll_in_divider, // usb ratio
	input wire logic debug_port_enable, // debug port on
	input wire logic two_wire_tdo_use, // tdo use
	input wire logic pin_select_lock, // pin lock
	input wire logic module_disable_lock // module lock
);
	logic [31:0] nv_q;
	logic dbg_q;
	// ****************************************
	// helper: inputs as seen at the previous edge
	// ****************************************
	always_ff @(posedge aclk)
	begin
		nv_q <= nv_pll_word;
		dbg_q <= nv_dbg_en;
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence rel;
		$rose(aresetn);
	endsequence
	// ****************************************
	// assertions
	// ****************************************
	chk_pin_gate: assert property (pin_wr_ok == (pin_wr_req && !pin_select_lock))
		else $error("pin select write gate wrong");
	chk_mod_gate: assert property (mod_wr_ok == (mod_wr_req && !module_disable_lock))
		else $error("module disable write gate wrong");
	chk_div_load: assert property (rel |=> pll_out_divisor ==
		((nv_q[18:16] == 3'h7) ? 9'h100 : 9'h1 << nv_q[18:16]))
		else $error("output divisor not loaded");
	chk_mult_load: assert property (rel |=> pll_multiplier ==
		((nv_q[6:4] == 3'h7) ? 5'h18 : 5'h0f + {2'h0, nv_q[6:4]}))
		else $error("multiplier not loaded");
	// a variant without usb shows the pll disabled and the divider at its first code
	chk_usb_load: assert property (rel |=> usb_pll_enable_n == (nv_q[15] || !has_usb) &&
		usb_pll_in_divider == (!has_usb ? 4'h1 : (nv_q[10:8] == 3'h7) ? 4'hc :
		(nv_q[10:8] == 3'h6) ? 4'ha : 4'h1 + {1'b0, nv_q[10:8]}))
		else $error("usb pll fields not loaded");
	chk_dbg_load: assert property (rel |=> debug_port_enable == dbg_q)
		else $error("debug enable not loaded");
	chk_reset_vals: assert property (rel |-> debug_port_enable && two_wire_tdo_use &&
		!pin_select_lock && !module_disable_lock)
		else $error("control reset value wrong");
	// the word may only move at a capture edge, never in normal running
	chk_word_hold: assert property ($past(aresetn) && $past(aresetn, 2) |->
		$stable(pll_multiplier) && $stable(pll_out_divisor) && $stable(usb_pll_in_divider))
		else $error("configuration word changed while running");
	chk_lock_write: assert property ($changed(pin_select_lock) || $changed(module_disable_lock)
		|-> ##[0:1] s_axi_bvalid)
		else $error("lock changed without a bus write");
endmodule
bind pll_config_and_lock_control pll_config_and_lock_control_sva #(.has_usb(has_usb)) chk_i (.aclk, .aresetn, .nv_pll_word,
	.nv_dbg_en, .s_axi_bvalid, .pin_wr_req, .mod_wr_req, .pin_wr_ok, .mod_wr_ok, .pll_out_divisor,
	.pll_multiplier, .usb_pll_enable_n, .usb_pll_in_divider, .debug_port_enable, .two_wire_tdo_use,
	.pin_select_lock, .module_disable_lock);
`default_nettype wire

// file: pll_config_and_lock_control_tb_top.sv
// Purpose: self-checking bench for the pll configuration and lock control block
// Assumes: axi4-lite master tasks, handshakes judged at the falling edge before the taking edge
// Notes: write strobes follow wr_strb, full words unless a scenario narrows them
`timescale 1ns/1ps
`default_nettype none
module pll_config_and_lock_control_tb_top;
	import pll_cfg_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, nv_dbg_en = 1'b0, pin_wr_req = 1'b0, mod_wr_req = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf, wr_strb = 4'hf;
	logic [31:0] nv_pll_word = 32'h0, s_axi_wdata = 32'h0, s_axi_rdata, w;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin_wr_ok, mod_wr_ok;
	logic usb_pll_enable_n, debug_port_enable, two_wire_tdo_use, pin_select_lock, module_disable_lock, nu_en_n;
	logic [3:0] nu_div;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] pll_in_divider;
	logic [8:0] pll_out_divisor;
	logic [4:0] pll_multiplier;
	logic [3:0] usb_pll_in_divider;
	logic [8:0] odt [8] = '{9'h1, 9'h2, 9'h4, 9'h8, 9'h10, 9'h20, 9'h40, 9'h100};
	logic [4:0] mlt [8] = '{5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h18};
	logic [3:0] udt [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha, 4'hc};
	int n_errors = 0, checks_done = 0;
	always #4 aclk = ~aclk;
	pll_config_and_lock_control dut (.aclk, .aresetn, .nv_pll_word, .nv_dbg_en, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_wr_req, .mod_wr_req, .pin_wr_ok,
		.mod_wr_ok, .pll_in_divider, .pll_out_divisor, .pll_multiplier, .usb_pll_enable_n,
		.usb_pll_in_divider, .debug_port_enable, .two_wire_tdo_use, .pin_select_lock, .module_disable_lock);
	// variant without the usb function, sharing every input with dut
	pll_config_and_lock_control #(.has_usb(1'b0)) dut_nousb (.aclk, .aresetn, .nv_pll_word, .nv_dbg_en,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .pin_wr_req,
		.mod_wr_req, .pin_wr_ok(), .mod_wr_ok(), .pll_in_divider(), .pll_out_divisor(), .pll_multiplier(),
		.usb_pll_enable_n(nu_en_n), .usb_pll_in_divider(nu_div), .debug_port_enable(), .two_wire_tdo_use(),
		.pin_select_lock(), .module_disable_lock());
	// ****************************************
	// report and compare
	// ****************************************
	task results();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask
	// a wait that ran out leaves the bus in an unknown state, so stop at once
	task tmo(input logic done);
		if (!done)
		begin
			$display("MISMATCH handshake expected done seen timeout");
			n_errors++;
			results();
		end
	endtask
	// ****************************************
	// bus and pin tasks
	// ****************************************
	task rst(input logic [31:0] wd, input logic dbg);
		@(posedge aclk);
		aresetn <= 1'b0;
		nv_pll_word <= wd;
		nv_dbg_en <= dbg;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		@(negedge aclk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ha, hw, hb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= wr_strb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		hb = 1'b0;
		for (int n = 0; n < 40 && !hb; n++)
		begin
			@(negedge aclk);
			ha = s_axi_awready;
			hw = s_axi_wready;
			hb = s_axi_bvalid;
			if (hb)
				chk("bresp", 32'(er), 32'(s_axi_bresp));
			@(posedge aclk);
			if (ha)
				s_axi_awvalid <= 1'b0;
			if (hw)
				s_axi_wvalid <= 1'b0;
			if (hb)
				s_axi_bready <= 1'b0;
		end
		tmo(hb);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ha, hr;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		hr = 1'b0;
		for (int n = 0; n < 40 && !hr; n++)
		begin
			@(negedge aclk);
			ha = s_axi_arready;
			hr = s_axi_rvalid;
			if (hr)
			begin
				chk("rdata", ed, s_axi_rdata);
				chk("rresp", 32'(er), 32'(s_axi_rresp));
			end
			@(posedge aclk);
			if (ha)
				s_axi_arvalid <= 1'b0;
			if (hr)
				s_axi_rready <= 1'b0;
		end
		tmo(hr);
	endtask
	task gate(input logic ok);
		@(posedge aclk);
		pin_wr_req <= 1'b1;
		mod_wr_req <= 1'b1;
		@(negedge aclk);
		chk("pin_wr_ok", 32'(ok), 32'(pin_wr_ok));
		chk("mod_wr_ok", 32'(ok), 32'(mod_wr_ok));
		@(posedge aclk);
		pin_wr_req <= 1'b0;
		mod_wr_req <= 1'b0;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		for (int c = 0; c < 8; c++)
		begin
			w = pll_word_reserved_mask | {13'h0, c[2:0], c[0], 4'h0, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0]};
			rst(w, c[1]);
			chk("out_div", 32'(odt[c]), 32'(pll_out_divisor));
			chk("usb_en_n", 32'(c[0]), 32'(usb_pll_enable_n));
			chk("usb_div", 32'(udt[c]), 32'(usb_pll_in_divider));
			chk("usb_en_n_nousb", 32'h1, 32'(nu_en_n));
			chk("usb_div_nousb", 32'h1, 32'(nu_div));
			chk("mult", 32'(mlt[c]), 32'(pll_multiplier));
			chk("in_div", 32'(c[2:0]), 32'(pll_in_divider));
			chk("dbg_en", 32'(c[1]), 32'(debug_port_enable));
			rd(pll_word_offset, w, resp_okay);
			rd(lock_ctrl_offset, {28'h0, c[1], 3'h7}, resp_okay);
		end
		wr(pll_word_offset, 32'h0, resp_okay);
		rd(pll_word_offset, w, resp_okay);
		wr(lock_ctrl_offset, 32'hffff_ffff, resp_okay);
		rd(lock_ctrl_offset, 32'hf, resp_okay);
		wr(lock_ctrl_offset, 32'h0, resp_okay);
		rd(lock_ctrl_offset, 32'h6, resp_okay);
		@(negedge aclk);
		chk("mult", 32'h18, 32'(pll_multiplier));
		chk("dbg_en", 32'h0, 32'(debug_port_enable));
		chk("tdo_use", 32'h0, 32'(two_wire_tdo_use));
		gate(1'b1);
		wr(unlock_offset, unlock_key1, resp_okay);
		rd(unlock_offset, 32'h1, resp_okay);
		wr(unlock_offset, unlock_key2, resp_okay);
		rd(unlock_offset, 32'h2, resp_okay);
		wr(lock_ctrl_offset, 32'h3009, resp_okay);
		rd(lock_ctrl_offset, 32'h300f, resp_okay);
		@(negedge aclk);
		chk("pin_lock", 32'h1, 32'(pin_select_lock));
		chk("mod_lock", 32'h1, 32'(module_disable_lock));
		gate(1'b0);
		// low byte only: debug and tdo move, the locks keep their value
		wr_strb = 4'h1;
		wr(lock_ctrl_offset, 32'h0, resp_okay);
		wr_strb = 4'hf;
		rd(lock_ctrl_offset, 32'h3006, resp_okay);
		// any unlock write while open closes it, so the locks can no longer be cleared
		wr(unlock_offset, 32'h0, resp_okay);
		wr(lock_ctrl_offset, 32'h9, resp_okay);
		rd(lock_ctrl_offset, 32'h300f, resp_okay);
		rd(4'hc, 32'h0, resp_slverr);
		wr(4'hc, 32'h0, resp_slverr);
		results();
	end
endmodule
`default_nettype wire
